// ==== shared/transceiver_regs.svh ====
`ifndef TRANSCEIVER_REGS_SVH
`define TRANSCEIVER_REGS_SVH

// Register byte addresses on the register bus.
`define XCVR_CTRL_ADDR 6'h00
`define XCVR_STATUS_ADDR 6'h04
`define XCVR_BACKPLANE_ADDR 6'h08
`define XCVR_COUNT_ADDR 6'h0C

// Control register field positions.
`define CTRL_FWD_MODE_LO 0
`define CTRL_FWD_MODE_HI 1
`define CTRL_RET_MODE_LO 2
`define CTRL_RET_MODE_HI 3
`define CTRL_FEEDBACK 4
`define CTRL_CARD_OE 5
`define CTRL_BP_EN 6
`define CTRL_BP_EN_N 7
`define CTRL_WIDTH 8

// Control reset value: every output off, both elements buffers.
`define CTRL_RESET 8'h80

// Status register field positions.
`define STATUS_FWD_LO 0
`define STATUS_RET_LO 8
`define STATUS_BUF_VALID 16
`define STATUS_BUF_READY 17
`define STATUS_CARD_ACTIVE 18
`define STATUS_BP_ACTIVE 19

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ==== shared/transceiver_pkg.sv ====
package transceiver_pkg;

  // Logic element configuration, one-hot.
  typedef enum logic [2:0] {
    mode_buffer = 3'b001,
    mode_flipflop = 3'b010,
    mode_latch = 3'b100
  } elem_mode_t;

  // Register bus write side progress, one-hot.
  typedef enum logic [2:0] {
    wr_collect = 3'b001,
    wr_respond = 3'b010,
    wr_unused = 3'b100
  } wr_state_t;

endpackage

// ==== design/two_entry_buffer.sv ====
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [PW-1:0] wr_ptr_inc = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
  wire [PW-1:0] rd_ptr_inc = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
  wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);

  assign out_data = store[rd_ptr];
  assign out_valid = (count != '0);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // Ready is registered so that it never depends on the drain side combinationally.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) wr_ptr <= wr_ptr_inc;
      if (pop) rd_ptr <= rd_ptr_inc;
      count <= next_count;
      in_ready <= (next_count != CW'(DEPTH));
    end
  end

endmodule // two_entry_buffer

`default_nettype wire

// ==== design/logic_element.sv ====
`timescale 1ns/100ps
`default_nettype none

module logic_element #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration
  input wire logic [1:0] mode_sel,
  input wire logic clock_or_enable,
  // Data
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out,
  output logic capture
);

  transceiver_pkg::elem_mode_t mode;
  logic enable_prev;
  wire rise = clock_or_enable & ~enable_prev;

  // Upper bit high means latch whatever the lower bit is.
  assign mode = mode_sel[1] ? transceiver_pkg::mode_latch :
                mode_sel[0] ? transceiver_pkg::mode_flipflop :
                transceiver_pkg::mode_buffer;

  always_comb begin
    case (mode)
      transceiver_pkg::mode_buffer: capture = 1'b1;
      transceiver_pkg::mode_flipflop: capture = rise;
      transceiver_pkg::mode_latch: capture = clock_or_enable;
      default: capture = 1'b0;
    endcase
  end

  // Without capture the stored word stays, which gives hold in both storing modes.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_prev <= 1'b0;
      data_out <= '0;
    end else begin
      enable_prev <= clock_or_enable;
      if (capture) data_out <= data_in;
    end
  end

endmodule // logic_element

`default_nettype wire

// ==== design/registered_transceiver.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "transceiver_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Eight lanes each carry a card input bit, a card output bit and a backplane bit.
// - Data is never inverted: card input goes to the backplane, backplane to card output.
// - The forward and the return element each have their own two-bit mode select.
// - Mode 00 is buffer, 01 is flip-flop, and 1x is latch.
// - A buffer registers its input on every cycle, so its output follows one cycle behind and never holds.
// - A flip-flop captures on the rising edge of its own direction's clock input.
// - A latch is transparent while its direction's clock input is high.
// - With feedback select low the return element takes the backplane data.
// - With feedback select high the return element takes the forward element output.
// - The card output port drives only while its output enable is high.
// - The backplane drives only with its high enable high and its low enable low.
// - Both elements keep working while their outputs are off.
module registered_transceiver #(
  parameter int WIDTH = 8,
  parameter int BUF_DEPTH = 2,
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Register bus write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Register bus write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Register bus read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Card side input stream
  input wire logic [WIDTH-1:0] card_input_port,
  input wire logic card_input_valid,
  output logic card_input_ready,
  // Card side output
  output logic [WIDTH-1:0] card_output_port,
  output logic card_output_oe_n,
  // Element strobes
  input wire logic forward_clock_or_enable,
  input wire logic return_clock_or_enable,
  // Backplane, open drain per lane
  input wire logic [WIDTH-1:0] backplane_in,
  output logic [WIDTH-1:0] backplane_out,
  output logic [WIDTH-1:0] backplane_oe_n
);

  //////////////////////////////////////////////////////////////////////////////
  // Control register and its fields.

  logic [`CTRL_WIDTH-1:0] ctrl;
  logic [31:0] word_count;
  logic count_clear;

  wire [1:0] forward_mode_sel = {ctrl[`CTRL_FWD_MODE_HI], ctrl[`CTRL_FWD_MODE_LO]};
  wire [1:0] return_mode_sel = {ctrl[`CTRL_RET_MODE_HI], ctrl[`CTRL_RET_MODE_LO]};
  wire feedback_select = ctrl[`CTRL_FEEDBACK];
  wire card_output_enable = ctrl[`CTRL_CARD_OE];
  wire backplane_drive_enable = ctrl[`CTRL_BP_EN];
  wire backplane_drive_enable_n = ctrl[`CTRL_BP_EN_N];
  wire backplane_active = backplane_drive_enable & ~backplane_drive_enable_n;

  //////////////////////////////////////////////////////////////////////////////
  // Card input buffer.

  logic [WIDTH-1:0] buf_data;
  logic buf_valid;
  logic fwd_capture;
  logic [WIDTH-1:0] held_word;
  wire buf_pop = buf_valid & fwd_capture;

  // A word waits here until the forward element is ready to take it.
  two_entry_buffer #(
    .WIDTH(WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_card_buffer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_data(card_input_port),
    .in_valid(card_input_valid),
    .in_ready(card_input_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(fwd_capture)
  );

  // With the buffer empty the element sees the last word taken, as a pin would.
  wire [WIDTH-1:0] fwd_data_in = buf_valid ? buf_data : held_word;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_word <= '0;
      word_count <= '0;
    end else begin
      if (buf_pop) held_word <= buf_data;
      if (count_clear) word_count <= '0;
      else if (buf_pop) word_count <= word_count + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Forward and return elements.

  logic [WIDTH-1:0] fwd_q;
  logic [WIDTH-1:0] ret_q;

  logic_element #(
    .WIDTH(WIDTH)
  ) u_forward_element (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .mode_sel(forward_mode_sel),
    .clock_or_enable(forward_clock_or_enable),
    .data_in(fwd_data_in),
    .data_out(fwd_q),
    .capture(fwd_capture)
  );

  // The return element listens to the backplane or to the forward element output.
  wire [WIDTH-1:0] ret_data_in = feedback_select ? fwd_q : backplane_in;

  logic_element #(
    .WIDTH(WIDTH)
  ) u_return_element (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .mode_sel(return_mode_sel),
    .clock_or_enable(return_clock_or_enable),
    .data_in(ret_data_in),
    .data_out(ret_q),
    .capture()
  );

  //////////////////////////////////////////////////////////////////////////////
  // Output drivers.

  // Data keeps flowing to the output flops while the driver is off.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      card_output_port <= '0;
      card_output_oe_n <= 1'b1;
    end else begin
      card_output_port <= ret_q;
      card_output_oe_n <= ~card_output_enable;
    end
  end

  // Each lane pulls low for a zero and releases for a one.
  genvar lane;
  generate
    for (lane = 0; lane < WIDTH; lane++) begin : g_lane
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          backplane_out[lane] <= 1'b1;
          backplane_oe_n[lane] <= 1'b1;
        end else begin
          backplane_out[lane] <= fwd_q[lane];
          backplane_oe_n[lane] <= ~(backplane_active & ~fwd_q[lane]);
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Register bus, write side.

  transceiver_pkg::wr_state_t wr_state;
  transceiver_pkg::wr_state_t next_wr_state;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire b_done = s_axi_bvalid & s_axi_bready;
  wire wr_fire = (wr_state == transceiver_pkg::wr_collect) & aw_held & w_held;
  wire wr_ctrl_hit = (aw_addr == `XCVR_CTRL_ADDR);
  wire wr_count_hit = (aw_addr == `XCVR_COUNT_ADDR);
  wire wr_ro_hit = (aw_addr == `XCVR_STATUS_ADDR) | (aw_addr == `XCVR_BACKPLANE_ADDR);
  wire wr_mapped = wr_ctrl_hit | wr_count_hit | wr_ro_hit;
  assign count_clear = wr_fire & wr_count_hit & w_strb[0];

  always_comb begin
    next_wr_state = wr_state;
    next_aw_held = aw_held | aw_take;
    next_w_held = w_held | w_take;
    case (wr_state)
      transceiver_pkg::wr_collect: begin
        if (wr_fire) next_wr_state = transceiver_pkg::wr_respond;
      end
      transceiver_pkg::wr_respond: begin
        if (b_done) begin
          next_wr_state = transceiver_pkg::wr_collect;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
        end
      end
      default: next_wr_state = transceiver_pkg::wr_collect;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_state <= transceiver_pkg::wr_collect;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      wr_state <= next_wr_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (aw_take) aw_addr <= s_axi_awaddr;
      if (w_take) w_data <= s_axi_wdata;
      if (w_take) w_strb <= s_axi_wstrb;
      s_axi_awready <= ~next_aw_held;
      s_axi_wready <= ~next_w_held;
    end
  end

  // Only byte lane zero carries control bits; other lanes are ignored.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (wr_fire & wr_ctrl_hit & w_strb[0]) ctrl <= w_data[`CTRL_WIDTH-1:0];
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_DECERR;
      end else if (b_done) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register bus, read side.

  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire r_done = s_axi_rvalid & s_axi_rready;
  wire rd_ctrl_hit = (s_axi_araddr == `XCVR_CTRL_ADDR);
  wire rd_status_hit = (s_axi_araddr == `XCVR_STATUS_ADDR);
  wire rd_bp_hit = (s_axi_araddr == `XCVR_BACKPLANE_ADDR);
  wire rd_count_hit = (s_axi_araddr == `XCVR_COUNT_ADDR);
  wire rd_mapped = rd_ctrl_hit | rd_status_hit | rd_bp_hit | rd_count_hit;

  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[`STATUS_FWD_LO +: WIDTH] = fwd_q;
    status_word[`STATUS_RET_LO +: WIDTH] = ret_q;
    status_word[`STATUS_BUF_VALID] = buf_valid;
    status_word[`STATUS_BUF_READY] = card_input_ready;
    status_word[`STATUS_CARD_ACTIVE] = ~card_output_oe_n;
    status_word[`STATUS_BP_ACTIVE] = backplane_active;
  end

  wire [31:0] rd_word = rd_ctrl_hit ? {{(32 - `CTRL_WIDTH){1'b0}}, ctrl} :
                        rd_status_hit ? status_word :
                        rd_bp_hit ? {{(32 - WIDTH){1'b0}}, backplane_in} :
                        rd_count_hit ? word_count : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_DECERR;
      end else if (r_done) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // registered_transceiver

`default_nettype wire

// ==== verification/registered_transceiver_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "transceiver_regs.svh"

module registered_transceiver_asserts #(
  parameter int WIDTH = 8,
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus write side
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Data pins
  input wire logic [WIDTH-1:0] card_output_port,
  input wire logic card_output_oe_n,
  input wire logic return_clock_or_enable,
  input wire logic [WIDTH-1:0] backplane_in,
  input wire logic [WIDTH-1:0] backplane_out,
  input wire logic [WIDTH-1:0] backplane_oe_n
);
  logic [ADDR_W-1:0] aw_q;
  logic [8:0] w_q;
  logic [7:0] ctrl;
  logic [1:0] age;
  wire logic settled = (age == 2'h3);
  wire logic bp_on = ctrl[6] & ~ctrl[7];
  wire logic ret_fb0 = settled & ctrl[5] & ~ctrl[4];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_q <= s_axi_awaddr;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_q <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
    end
  end

  // Mirror of the control register, taken once the write is answered.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `CTRL_RESET;
      age <= 2'h0;
    end else if (s_axi_bvalid && s_axi_bready && aw_q == '0 && w_q[8]) begin
      ctrl <= w_q[7:0];
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_bp_pins;
    @(posedge sys_clk) disable iff (!rst_n)
      settled |-> backplane_oe_n == (bp_on ? backplane_out : '1);
  endproperty
  a_bp_pins: assert property (p_bp_pins) else $error("backplane drive wrong");
  property p_card_oe;
    @(posedge sys_clk) disable iff (!rst_n) settled |-> card_output_oe_n == !ctrl[5];
  endproperty
  a_card_oe: assert property (p_card_oe) else $error("card enable wrong");
  property p_ret_buf;
    @(posedge sys_clk) disable iff (!rst_n)
      ret_fb0 && ctrl[3:2] == 2'h0 |-> card_output_port == $past(backplane_in, 2);
  endproperty
  a_ret_buf: assert property (p_ret_buf) else $error("return buffer wrong");
  property p_feedback;
    @(posedge sys_clk) disable iff (!rst_n)
      settled && ctrl[5:4] == 2'h3 && ctrl[3:2] == 2'h0 |-> card_output_port == $past(backplane_out);
  endproperty
  a_feedback: assert property (p_feedback) else $error("feedback path wrong");
  property p_latch_open;
    @(posedge sys_clk) disable iff (!rst_n)
      ret_fb0 && ctrl[3] && $past(return_clock_or_enable, 2) |->
        card_output_port == $past(backplane_in, 2);
  endproperty
  a_latch_open: assert property (p_latch_open) else $error("latch not transparent");
  property p_latch_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      ret_fb0 && ctrl[3] && !$past(return_clock_or_enable, 2) |-> $stable(card_output_port);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch did not hold");
  property p_ff_take;
    @(posedge sys_clk) disable iff (!rst_n)
      ret_fb0 && ctrl[3:2] == 2'h1 && $past(return_clock_or_enable, 2) &&
        !$past(return_clock_or_enable, 3) |-> card_output_port == $past(backplane_in, 2);
  endproperty
  a_ff_take: assert property (p_ff_take) else $error("flip-flop missed edge");
  property p_ff_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      ret_fb0 && ctrl[3:2] == 2'h1 && !($past(return_clock_or_enable, 2) &&
        !$past(return_clock_or_enable, 3)) |-> $stable(card_output_port);
  endproperty
  a_ff_hold: assert property (p_ff_hold) else $error("flip-flop did not hold");
endmodule // registered_transceiver_asserts

bind registered_transceiver registered_transceiver_asserts #(.WIDTH(WIDTH), .ADDR_W(ADDR_W))
  registered_transceiver_asserts_i (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .card_output_port, .card_output_oe_n, .return_clock_or_enable,
  .backplane_in, .backplane_out, .backplane_oe_n);

`default_nettype wire

// ==== verification/backplane_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module backplane_model #(
  parameter int WIDTH = 8
) (
  // Device lanes
  input wire logic [WIDTH-1:0] backplane_out,
  input wire logic [WIDTH-1:0] backplane_oe_n,
  // Other cards sinking lanes
  input wire logic [WIDTH-1:0] other_pull,
  // Resolved lane levels
  output logic [WIDTH-1:0] backplane_in
);
  // Termination holds a lane high unless some card sinks it.
  assign backplane_in = ~((~backplane_oe_n & ~backplane_out) | other_pull);
endmodule // backplane_model

`default_nettype wire

// ==== verification/registered_transceiver_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "transceiver_regs.svh"

module registered_transceiver_bench;
  typedef struct packed {
    logic [7:0] ctrl;
    logic fen;
    logic [7:0] word;
    logic [7:0] other;
    logic oe_n;
    logic [7:0] out;
    logic [7:0] bpoe;
  } row_t;
  row_t rows [8] = '{'{8'h20, 1'h0, 8'h3C, 8'h5A, 1'h0, 8'hA5, 8'hFF},
    '{8'h60, 1'h0, 8'h3C, 8'h00, 1'h0, 8'h3C, 8'h3C}, '{8'h60, 1'h0, 8'hF0, 8'h0F, 1'h0, 8'hF0, 8'hF0},
    '{8'hE0, 1'h0, 8'h00, 8'h00, 1'h0, 8'hFF, 8'hFF}, '{8'hA0, 1'h0, 8'h5A, 8'h00, 1'h0, 8'hFF, 8'hFF},
    '{8'h30, 1'h0, 8'h96, 8'h00, 1'h0, 8'h96, 8'hFF}, '{8'h32, 1'h1, 8'hC3, 8'h00, 1'h0, 8'hC3, 8'hFF},
    '{8'h00, 1'h0, 8'h11, 8'h00, 1'h1, 8'h00, 8'hFF}};
  logic [7:0] lmodes [2] = '{8'h28, 8'h2C};
  logic [7:0] fwd_exp [3] = '{8'hA1, 8'hA2, 8'hA2};
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [1:0] wr_exp = `RESP_OKAY;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] card_input_port = '0, card_output_port, other_pull = '0;
  logic card_input_valid = 1'h0, card_input_ready, card_output_oe_n;
  logic forward_clock_or_enable = 1'h0, return_clock_or_enable = 1'h0;
  logic [7:0] backplane_in, backplane_out, backplane_oe_n;

  registered_transceiver registered_transceiver_i (.sys_clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .card_input_port,
    .card_input_valid, .card_input_ready, .card_output_port, .card_output_oe_n,
    .forward_clock_or_enable, .return_clock_or_enable, .backplane_in, .backplane_out,
    .backplane_oe_n);
  backplane_model backplane_model_i (.backplane_out, .backplane_oe_n, .other_pull,
    .backplane_in);

  ////////////////////////////////////////////////////////////////////////////////
  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic axi_write(input logic [5:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    check(s_axi_bresp, wr_exp);
    s_axi_bready <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic axi_read(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    check(s_axi_rresp, er);
    if (er == `RESP_OKAY) check(s_axi_rdata, exp);
    s_axi_rready <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic send_word(input logic [7:0] w);
    card_input_port <= w;
    card_input_valid <= 1'h1;
    do @(posedge sys_clk); while (card_input_ready !== 1'h1);
    card_input_valid <= 1'h0;
  endtask

  task automatic strobe(input logic fwd);
    if (fwd) forward_clock_or_enable <= 1'h1;
    else return_clock_or_enable <= 1'h1;
    repeat (2) @(posedge sys_clk);
    forward_clock_or_enable <= 1'h0;
    return_clock_or_enable <= 1'h0;
    repeat (2) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    check(card_output_oe_n, 1'h1);
    check(backplane_oe_n, 8'hFF);
    axi_read(`XCVR_CTRL_ADDR, 32'h0000_0080, `RESP_OKAY);
    axi_write(`XCVR_STATUS_ADDR, 32'hFFFF_FFFF);
    axi_read(`XCVR_CTRL_ADDR, 32'h0000_0080, `RESP_OKAY);
    axi_read(`XCVR_BACKPLANE_ADDR, 32'h0000_00FF, `RESP_OKAY);
    axi_read(6'h10, 32'h0000_0000, `RESP_DECERR);
    $display("registers done");
    foreach (rows[i]) begin
      forward_clock_or_enable <= rows[i].fen;
      other_pull <= rows[i].other;
      axi_write(`XCVR_CTRL_ADDR, {24'h00_0000, rows[i].ctrl});
      send_word(rows[i].word);
      settle;
      check(card_output_oe_n, rows[i].oe_n);
      if (!rows[i].oe_n) check(card_output_port, rows[i].out);
      check(backplane_oe_n, rows[i].bpoe);
      $display("row %0d done", i);
    end
    forward_clock_or_enable <= 1'h0;
    axi_write(`XCVR_CTRL_ADDR, 32'h0000_0004);
    other_pull <= 8'hEE;
    strobe(1'h0);
    axi_write(`XCVR_CTRL_ADDR, 32'h0000_0024);
    settle;
    check(card_output_port, 8'h11);
    other_pull <= 8'hDD;
    settle;
    check(card_output_port, 8'h11);
    strobe(1'h0);
    check(card_output_port, 8'h22);
    return_clock_or_enable <= 1'h1;
    settle;
    other_pull <= 8'hCC;
    settle;
    check(card_output_port, 8'h22);
    return_clock_or_enable <= 1'h0;
    $display("return flip-flop done");
    foreach (lmodes[k]) begin
      axi_write(`XCVR_CTRL_ADDR, {24'h00_0000, lmodes[k]});
      return_clock_or_enable <= 1'h1;
      other_pull <= 8'hBB;
      settle;
      check(card_output_port, 8'h44);
      other_pull <= 8'hAA;
      settle;
      check(card_output_port, 8'h55);
      return_clock_or_enable <= 1'h0;
      other_pull <= 8'h99;
      settle;
      check(card_output_port, 8'h55);
    end
    $display("return latch done");
    axi_write(`XCVR_CTRL_ADDR, 32'h0000_0001);
    send_word(8'hA1);
    @(posedge sys_clk);
    send_word(8'hA2);
    @(posedge sys_clk);
    card_input_port <= 8'hA3;
    card_input_valid <= 1'h1;
    settle;
    check(card_input_ready, 1'h0);
    card_input_valid <= 1'h0;
    foreach (fwd_exp[k]) begin
      strobe(1'h1);
      check(backplane_out, fwd_exp[k]);
    end
    axi_write(`XCVR_CTRL_ADDR, 32'h0000_0041);
    settle;
    check(backplane_oe_n, 8'hA2);
    $display("forward buffer done");
    axi_read(`XCVR_COUNT_ADDR, 32'h0000_000A, `RESP_OKAY);
    axi_read(`XCVR_STATUS_ADDR, 32'h000A_22A2, `RESP_OKAY);
    axi_write(`XCVR_COUNT_ADDR, 32'h0000_0001);
    axi_read(`XCVR_COUNT_ADDR, 32'h0000_0000, `RESP_OKAY);
    wr_exp = `RESP_DECERR;
    axi_write(6'h10, 32'h0000_00FF);
    wr_exp = `RESP_OKAY;
    axi_read(`XCVR_CTRL_ADDR, 32'h0000_0041, `RESP_OKAY);
    $display("registers after traffic done");
    print_verdict;
  end
endmodule // registered_transceiver_bench

`default_nettype wire
